// >>> rcu_pkg.sv
// rcu_pkg: constants and carrier types for the register-change unit
// assumes a 24-bit word, bit 0 of the instruction word is its msb
package rcu_pkg;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned EXP_W = 9;
    // instruction word fields, vector index = 23 - printed bit number
    localparam int unsigned OP_HI = 20;
    localparam int unsigned OP_LO = 15;
    localparam logic [5:0] OP_REG_CHANGE = 6'h26;
    localparam int unsigned BIT_CLR_X = 22;
    localparam int unsigned BIT_NEG_A = 9;
    localparam int unsigned BIT_NEG_ALT = 12;
    localparam int unsigned BIT_A2X = 8;
    localparam int unsigned BIT_X2A = 7;
    localparam int unsigned BIT_EXP = 6;
    localparam int unsigned BIT_X2B = 5;
    localparam int unsigned BIT_B2X = 4;
    localparam int unsigned BIT_B2A = 3;
    localparam int unsigned BIT_A2B = 2;
    localparam int unsigned BIT_CLR_B = 1;
    localparam int unsigned BIT_CLR_A = 0;
    localparam int unsigned EXP_SIGN = 8;
    localparam logic [WORD_W-1:0] FULL_MASK = 24'hffffff;
    localparam logic [WORD_W-1:0] EXP_MASK = 24'h0001ff;
    // apb register map, byte addresses
    localparam logic [7:0] ADR_ACC = 8'h00;
    localparam logic [7:0] ADR_EXT = 8'h04;
    localparam logic [7:0] ADR_IDX = 8'h08;
    localparam logic [7:0] ADR_EXEC = 8'h0c;
    localparam logic [7:0] ADR_STAT = 8'h10;
    // status layout
    localparam int unsigned STAT_REJ = 16;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic [WORD_W-1:0] acc;
        logic [WORD_W-1:0] ext;
        logic [WORD_W-1:0] idx;
    } regs_t;

    typedef struct packed {
        regs_t r;
        logic [WORD_W-1:0] last;
        logic [CNT_W-1:0] count;
        logic rej;
        logic done;
    } rcu_state_t;
endpackage : rcu_pkg

// >>> rcu_datapath.sv
// rcu_datapath: combinational next values of acc, ext and idx
// assumes the caller registers the result; inputs are pre-cycle values
`timescale 1ns/1ps
`default_nettype none
module rcu_datapath
    import rcu_pkg::*;
(
    input wire logic [WORD_W-1:0] word,
    input wire regs_t cur,
    output regs_t nxt
);
    logic clr_x, clr_a, clr_b, neg, exp_only;
    logic a2x, x2a, x2b, b2x, b2a, a2b;
    logic a_wr, b_wr, x_wr;
    logic [WORD_W-1:0] mask, a_src, b_src, x_src, neg_a, x_tmp;

    always_comb begin
        clr_x = word[BIT_CLR_X];
        clr_a = word[BIT_CLR_A];
        clr_b = word[BIT_CLR_B];
        // both encodings of negate are honoured
        neg = word[BIT_NEG_A] | word[BIT_NEG_ALT];
        exp_only = word[BIT_EXP];
        a2x = word[BIT_A2X];
        x2a = word[BIT_X2A];
        x2b = word[BIT_X2B];
        b2x = word[BIT_B2X];
        b2a = word[BIT_B2A];
        a2b = word[BIT_A2B];
        mask = exp_only ? EXP_MASK : FULL_MASK;
        neg_a = WORD_W'(~cur.acc + 24'h000001);
        // sources merge by or when two feed one register
        a_src = (x2a ? cur.idx : '0) | (b2a ? cur.ext : '0)
            | (neg ? neg_a : '0);
        b_src = (a2b ? cur.acc : '0)
            | (x2b ? cur.idx : '0);
        x_src = (a2x ? cur.acc : '0)
            | (b2x ? cur.ext : '0);
        a_wr = x2a | b2a | neg;
        b_wr = a2b | x2b;
        x_wr = a2x | b2x;
        // a copy into a register overrides its clear
        if (a_wr) begin
            nxt.acc = (cur.acc & ~mask) | (a_src & mask);
        end else if (clr_a) begin
            nxt.acc = cur.acc & ~mask;
        end else begin
            nxt.acc = cur.acc;
        end
        if (b_wr) begin
            nxt.ext = (cur.ext & ~mask) | (b_src & mask);
        end else if (clr_b) begin
            nxt.ext = cur.ext & ~mask;
        end else begin
            nxt.ext = cur.ext;
        end
        if (x_wr) begin
            x_tmp = (cur.idx & ~mask) | (x_src & mask);
        end else if (clr_x) begin
            x_tmp = cur.idx & ~mask;
        end else begin
            x_tmp = cur.idx;
        end
        // exponent sign fills the upper index bits
        if (exp_only && (x_wr || clr_x)) begin
            nxt.idx = {{(WORD_W-EXP_W){x_tmp[EXP_SIGN]}},
                x_tmp[EXP_W-1:0]};
        end else begin
            nxt.idx = x_tmp;
        end
    end
endmodule : rcu_datapath
`default_nettype wire

// >>> register_change_unit.sv
// register_change_unit: acc/ext/idx registers and register-change ops
// assumes the decoder drives exec_valid/exec_word on core_clk, and an
// apb master on the same clock for software access to the registers
// Function
// - field 00002 clears extension only
// - field 00003 clears acc and extension
// - index-clear bit, field 00000 clears index
// - index-clear bit, field 00003 clears all three
// - copy accumulator into extension
// - field 00010 copies extension into accumulator
// - swap accumulator and extension in one cycle
// - field 00005 moves acc to extension, zeroes acc
// - field 00012 moves extension to acc, zeroes extension
// - copy accumulator into index
// - field 00200 copies index into accumulator
// - field 00600 swaps index and accumulator
// - copy extension into index
// - copy index into extension
// - field 00060 swaps index and extension
// - store exponent, sign-extend index, clear field
// - load exponent replaces low nine extension bits
// - field 00160 swaps exponents, sign-extends index
// - field 10000 negates accumulator
// - each field bit selects one function
// - two sources into one destination merge
// - copy wins over clear on same register
// - any combination completes in one cycle
`timescale 1ns/1ps
`default_nettype none
module register_change_unit
    import rcu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic exec_valid,
    input wire logic [WORD_W-1:0] exec_word,
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    output logic [WORD_W-1:0] acc_out,
    output logic [WORD_W-1:0] ext_out,
    output logic [WORD_W-1:0] idx_out,
    output logic exec_done
);
    rcu_state_t st_q, st_d;
    regs_t dp_next;
    logic [WORD_W-1:0] op_word;
    logic op_go, op_match;
    logic acc_phase, apb_take, apb_wr, apb_exec, addr_ok;
    logic [31:0] rd_mux;

    // decoder owns the cycle; apb waits rather than race a register write
    assign acc_phase = apb_req.psel & apb_req.penable;
    assign apb_take = acc_phase & ~exec_valid;
    assign apb_wr = apb_take & apb_req.pwrite;
    assign apb_exec = apb_wr & (apb_req.paddr == ADR_EXEC);

    always_comb begin
        case (apb_req.paddr)
            ADR_ACC: addr_ok = 1'b1;
            ADR_EXT: addr_ok = 1'b1;
            ADR_IDX: addr_ok = 1'b1;
            ADR_EXEC: addr_ok = 1'b1;
            ADR_STAT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_comb begin
        case (apb_req.paddr)
            ADR_ACC: rd_mux = {8'h00, st_q.r.acc};
            ADR_EXT: rd_mux = {8'h00, st_q.r.ext};
            ADR_IDX: rd_mux = {8'h00, st_q.r.idx};
            ADR_EXEC: rd_mux = {8'h00, st_q.last};
            ADR_STAT: rd_mux = {15'h0000, st_q.rej, st_q.count};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // one driver for the whole response struct
    assign apb_rsp = '{pready: ~exec_valid,
        pslverr: acc_phase & ~addr_ok,
        prdata: (acc_phase & ~apb_req.pwrite) ? rd_mux : 32'h00000000};

    // one instruction source per cycle, decoder first
    assign op_word = exec_valid ? exec_word : apb_req.pwdata[WORD_W-1:0];
    assign op_go = exec_valid | apb_exec;
    assign op_match = (op_word[OP_HI:OP_LO] == OP_REG_CHANGE);

    // datapath sees only registered values, so swaps need no temp
    rcu_datapath u_dp (
        .word(op_word),
        .cur(st_q.r),
        .nxt(dp_next)
    );

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (op_go) begin
            if (op_match) begin
                st_d.r = dp_next;
                st_d.last = op_word;
                st_d.count = st_q.count + 16'h0001;
                st_d.done = 1'b1;
                st_d.rej = 1'b0;
            end else begin
                // foreign opcode leaves the registers alone
                st_d.rej = 1'b1;
            end
        end else if (apb_wr) begin
            case (apb_req.paddr)
                ADR_ACC: st_d.r.acc = apb_req.pwdata[WORD_W-1:0];
                ADR_EXT: st_d.r.ext = apb_req.pwdata[WORD_W-1:0];
                ADR_IDX: st_d.r.idx = apb_req.pwdata[WORD_W-1:0];
                ADR_STAT: begin
                    st_d.count = CNT_RST;
                    st_d.rej = 1'b0;
                end
                default: st_d.rej = st_q.rej;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q.r.acc <= WORD_RST;
            st_q.r.ext <= WORD_RST;
            st_q.r.idx <= WORD_RST;
            st_q.last <= WORD_RST;
            st_q.count <= CNT_RST;
            st_q.rej <= 1'b0;
            st_q.done <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign acc_out = st_q.r.acc;
    assign ext_out = st_q.r.ext;
    assign idx_out = st_q.r.idx;
    assign exec_done = st_q.done;
endmodule : register_change_unit
`default_nettype wire

// >>> rcu_monitor.sv
// rcu_monitor: port assertions for the register-change unit
// assumes binding into register_change_unit, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rcu_monitor
    import rcu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic exec_valid,
    input wire logic [WORD_W-1:0] exec_word,
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    input wire logic [WORD_W-1:0] acc_out,
    input wire logic [WORD_W-1:0] ext_out,
    input wire logic [WORD_W-1:0] idx_out,
    input wire logic exec_done
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic ok;
    logic [15:0] f;
    // index-clear bit joined to the field so one compare names the op
    assign ok = exec_valid && exec_word[20:15] == OP_REG_CHANGE;
    assign f = {exec_word[22], exec_word[14:0]};
    done_pulse_a: assert property (ok |=> exec_done)
        else $error("done missing after op");
    bad_hold_a: assert property (exec_valid && !ok |=> !exec_done
        && $stable({acc_out, ext_out, idx_out})) else $error("bad op acted");
    clr_ext_a: assert property (ok && f == 16'h0002 |=>
        ext_out == '0 && $stable(acc_out)) else $error("clear ext wrong");
    swap_ab_a: assert property (ok && f == 16'h000c |=>
        acc_out == $past(ext_out) && ext_out == $past(acc_out))
        else $error("acc ext swap wrong");
    neg_acc_a: assert property (ok && f == 16'h1000 |=>
        acc_out == -$past(acc_out)) else $error("negate wrong");
    swap_xa_a: assert property (ok && f == 16'h0180 |=>
        idx_out == $past(acc_out) && acc_out == $past(idx_out))
        else $error("idx acc swap wrong");
    clr_all_a: assert property (ok && f == 16'h8003 |=>
        {acc_out, ext_out, idx_out} == '0) else $error("clear all wrong");
    hold_regs_a: assert property (!exec_valid && !apb_req.psel |=>
        $stable({acc_out, ext_out, idx_out})) else $error("regs moved idle");
    stall_bus_a: assert property (exec_valid |-> !apb_rsp.pready)
        else $error("bus not stalled");
    cover property (ok ##1 ok);
    cover property (exec_valid && apb_req.psel && apb_req.penable);
    cover property (exec_valid && !ok);
    cover property (ok && exec_word[6]);
endmodule : rcu_monitor
bind register_change_unit rcu_monitor i_rcu_monitor (.core_clk, .rst,
    .exec_valid, .exec_word, .apb_req, .apb_rsp, .acc_out, .ext_out,
    .idx_out, .exec_done);
`default_nettype wire

// >>> tb_top.sv
// tb_top: self-checking bench for register_change_unit
// assumes rcu_monitor is bound in; bench drives decoder and apb ports
`timescale 1ns/1ps
`default_nettype none
module tb_top import rcu_pkg::*;;
    logic core_clk;
    logic rst;
    logic exec_valid;
    logic exec_done;
    logic [23:0] exec_word;
    apb_req_t apb_req;
    apb_rsp_t apb_rsp;
    wire regs_t r;
    regs_t e;
    int failures;
    int checks;
    int cnt;
    logic rej;
    logic [31:0] rd;
    logic err;
    logic [23:0] wq[$];
    // x bit in 15, field in 14:0
    localparam logic [15:0] OPS [22] = '{
        16'h0002, 16'h0003, 16'h8000, 16'h8003,
        16'h0004, 16'h0008, 16'h000c, 16'h0005,
        16'h000a, 16'h0100, 16'h0080, 16'h0180,
        16'h0010, 16'h0020, 16'h0030, 16'h0052,
        16'h0060, 16'h0070, 16'h1000, 16'h0200,
        16'h0088, 16'h0006};
    register_change_unit i_register_change_unit (.core_clk, .rst, .exec_valid,
        .exec_word, .apb_req, .apb_rsp, .acc_out(r.acc), .ext_out(r.ext),
        .idx_out(r.idx), .exec_done);
    function automatic logic [23:0] rc(logic [15:0] f);
        return {1'b0, f[15], 1'b0, OP_REG_CHANGE, f[14:0]};
    endfunction : rc
    function automatic logic [23:0] pick(logic [23:0] o, s, logic sel, clr,
        logic [23:0] m);
        return sel ? (o & ~m) | (s & m) : clr ? o & ~m : o;
    endfunction : pick
    function automatic regs_t model(logic [23:0] w, regs_t c);
        logic [23:0] m;
        regs_t n;
        m = w[6] ? EXP_MASK : FULL_MASK;
        n.acc = pick(c.acc, (w[7] ? c.idx : '0) | (w[3] ? c.ext : '0)
            | (w[9] | w[12] ? -c.acc : '0), |{w[12], w[9], w[7], w[3]}, w[0], m);
        n.ext = pick(c.ext, (w[2] ? c.acc : '0) | (w[5] ? c.idx : '0),
            w[2] | w[5], w[1], m);
        n.idx = pick(c.idx, (w[8] ? c.acc : '0) | (w[4] ? c.ext : '0),
            w[8] | w[4], w[22], m);
        if (w[6] && (w[8] | w[4] | w[22]))
            n.idx[23:9] = {15{n.idx[8]}};
        return w[20:15] == OP_REG_CHANGE ? n : c;
    endfunction : model
    function automatic void note(logic [23:0] w);
        e = model(w, e);
        rej = w[20:15] != OP_REG_CHANGE;
        cnt += int'(!rej);
    endfunction : note
    task automatic chk(string n, logic [71:0] s, x);
        checks++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        // no fixed wait: the decoder may stall the bus
        do begin
            @(posedge core_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        failures += int'(n == 50);
        apb_req <= '0;
        if (wr && a < ADR_EXEC)
            e[71 - 6 * int'(a) -: 24] = d[23:0];
        else if (wr && a == ADR_EXEC)
            note(d[23:0]);
        else if (wr && a == ADR_STAT)
            {cnt, rej} = '0;
        #1;
    endtask : apb
    task automatic run();
        @(posedge core_clk);
        exec_valid <= 1'b1;
        exec_word <= wq[0];
        foreach (wq[i]) begin
            @(posedge core_clk);
            if (i + 1 < wq.size())
                exec_word <= wq[i + 1];
            else
                exec_valid <= 1'b0;
            note(wq[i]);
            #1;
            chk("regs", r, e);
            chk("done", exec_done, !rej);
        end
        wq = {};
    endtask : run
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #40000;
        failures++;
        final_report();
    end
    initial begin
        logic [23:0] w;
        {rst, exec_valid, exec_word, apb_req, e} =
            {1'b1, 1'b0, 24'h000000, 43'h0, 72'h0};
        {failures, checks, cnt, rej} = '0;
        void'($urandom(88));
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 0; a < 24; a += 4) begin
            apb(1'b0, 8'(a), '0);
            chk("reset read", rd, '0);
            chk("slverr", err, a == 20);
        end
        foreach (OPS[i]) begin
            for (int k = 0; k < 3; k++) apb(1'b1, 8'(4 * k), $urandom);
            wq.push_back(rc(OPS[i]));
            run();
        end
        // long back-to-back burst, one in eight with a foreign opcode
        for (int k = 0; k < 3; k++) apb(1'b1, 8'(4 * k), $urandom);
        repeat (60) begin
            w = 24'($urandom) & 24'h5fffff;
            w[14:0] &= 15'h13bf;
            if ($urandom % 8 != 0) w[20:15] = OP_REG_CHANGE;
            wq.push_back(w);
        end
        run();
        apb(1'b1, ADR_EXEC, 32'(rc(16'h000c)));
        chk("bus exec", r, e);
        apb(1'b0, ADR_EXEC, '0);
        chk("last word", rd, rc(16'h000c));
        apb(1'b0, ADR_STAT, '0);
        chk("status", rd, {rej, cnt[15:0]});
        // clear lands only once the decoder lets go of the bus
        for (int k = 0; k < 3; k++) wq.push_back(rc(OPS[k + 4]));
        fork
            run();
            apb(1'b1, ADR_STAT, '0);
        join
        apb(1'b0, ADR_STAT, '0);
        chk("status clr", rd, '0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
